// >>> include/event_timer_pkg.sv
// Package with the register map, field layout and timing constants of the event timer.
package event_timer_pkg;

    // Byte addresses of the registers on the plain register port.
    localparam logic [7:0]  CONFIG_OFFSET    = 8'h00;
    localparam logic [7:0]  PRESET_OFFSET    = 8'h04;
    localparam logic [7:0]  COUNT_OFFSET     = 8'h08;
    localparam logic [7:0]  STATUS_OFFSET    = 8'h0C;

    // Field positions inside the configuration register.
    localparam int          RELOAD_BIT       = 1;
    localparam int          MODE_BIT         = 2;
    localparam int          RATE_LSB         = 3;
    localparam int          RATE_MSB         = 5;
    localparam int          NOW_BIT          = 6;
    localparam int          OWN_OFF_BIT      = 7;
    localparam int          OWN_ON_BIT       = 8;
    localparam int          EXT_OFF_BIT      = 9;
    localparam int          EXT_ON_BIT       = 10;
    localparam int          TX_DONE_BIT      = 11;

    // Field positions inside the status register.
    localparam int          STAT_RUN_BIT     = 0;
    localparam int          STAT_EXPIRED_BIT = 1;

    // Widths of the configuration word and of the counter.
    localparam int          CFG_WIDTH        = 12;
    localparam int          COUNT_WIDTH      = 20;

    // Reset values and the mask of writable configuration bits.
    localparam logic [11:0] CONFIG_RESET     = 12'h000;
    localparam logic [11:0] CFG_WRITE_MASK   = 12'hFFE;
    localparam logic [19:0] PRESET_RESET     = 20'h00000;
    localparam logic [19:0] COUNT_RESET      = 20'h00000;

    // Clock rates in Hz; the interface tick is made by a phase accumulator.
    localparam int          CORE_CLK_HZ      = 125000000;
    localparam int          IF_CLK_HZ        = 13560000;
    localparam int          PHASE_GCD        = 40000;
    localparam logic [11:0] PHASE_STEP       = 12'(IF_CLK_HZ / PHASE_GCD);
    localparam logic [11:0] PHASE_MODULUS    = 12'(CORE_CLK_HZ / PHASE_GCD);

endpackage : event_timer_pkg

// >>> src/tick_prescaler.sv
// Interface-clock tick generator and power-of-two prescaler for the event timer.
`timescale 1ns/100ps

module tick_prescaler
(
    // Clock, reset and enable.
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // Rate selection.
    input  wire logic [2:0] tick_rate_select,
    // Tick outputs, one cycle each.
    output logic            base_tick,
    output logic            scaled_tick
);

    typedef struct packed {
        logic [11:0] phase;
        logic [7:0]  div;
        logic        base_tick;
        logic        scaled_tick;
    } presc_state_t;

    presc_state_t s_reg;
    presc_state_t s_next;
    logic [12:0]  phase_sum;
    logic [7:0]   div_mask;

    // The accumulator yields 13.56 MHz on average; single ticks jitter by one core cycle.
    always_comb
    begin
        s_next             = s_reg;
        s_next.base_tick   = 1'b0;
        s_next.scaled_tick = 1'b0;
        phase_sum = {1'b0, s_reg.phase} + {1'b0, event_timer_pkg::PHASE_STEP};
        div_mask  = 8'hFF >> (3'h7 - tick_rate_select);
        if (phase_sum >= {1'b0, event_timer_pkg::PHASE_MODULUS})
        begin
            s_next.phase     = 12'(phase_sum - {1'b0, event_timer_pkg::PHASE_MODULUS});
            s_next.base_tick = 1'b1;
            // Divide by two to the power of select plus one.
            if ((s_reg.div & div_mask) == div_mask)
            begin
                s_next.scaled_tick = 1'b1;
            end
            s_next.div = s_reg.div + 8'h01;
        end
        else
        begin
            s_next.phase = phase_sum[11:0];
        end
    end

    // State register, frozen while the enable is low.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_reg <= '0;
        end
        else if (ce)
        begin
            s_reg <= s_next;
        end
    end

    assign base_tick   = s_reg.base_tick;
    assign scaled_tick = s_reg.scaled_tick;

    AST_SCALED_SUBSET: assert property (@(posedge core_clk) disable iff (rst)
        scaled_tick |-> base_tick)
        else $error("Scaled tick without an interface tick.");

    AST_BASE_SPACING: assert property (@(posedge core_clk) disable iff (rst)
        (base_tick && ce) |=> !base_tick)
        else $error("Interface ticks in consecutive cycles.");

endmodule : tick_prescaler

// >>> src/event_timer.sv
// Event-started down-counting timer with register port, start sources and prescaling.
`timescale 1ns/100ps

module event_timer
(
    // Clock, reset and enable.
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Field and transmitter events.
    input  wire logic        ext_field_pin,
    input  wire logic        own_field_on,
    input  wire logic        tx_done,
    // Timer status.
    output logic             timer_running,
    output logic             expire_pulse
);

    typedef struct packed {
        logic        ext_s1;
        logic        ext_s2;
        logic        ext_prev;
        logic        own_prev;
        logic [11:0] cfg;
        logic [19:0] preset;
        logic [19:0] count;
        logic        running;
        logic        expired;
        logic        expire_pulse;
        logic [31:0] rd_data;
    } timer_state_t;

    timer_state_t s;
    timer_state_t s_next;

    logic       base_tick;
    logic       scaled_tick;
    logic       tick;
    logic       cfg_wr;
    logic       preset_wr;
    logic       status_wr;
    logic       stop_req;
    logic       clear_req;
    logic       now_req;
    logic       ext_rise;
    logic       ext_fall;
    logic       own_rise;
    logic       own_fall;
    logic       start_evt;
    logic       expiry;

    // Tick source, steered by the stored rate select.
    tick_prescaler u_prescaler
    (
        .core_clk         (core_clk),
        .rst              (rst),
        .ce               (ce),
        .tick_rate_select (s.cfg[event_timer_pkg::RATE_MSB:event_timer_pkg::RATE_LSB]),
        .base_tick        (base_tick),
        .scaled_tick      (scaled_tick)
    );

    // Mode zero ignores the rate select and counts every interface tick.
    assign tick = s.cfg[event_timer_pkg::MODE_BIT] ? scaled_tick : base_tick;

    // Register strobes decoded against the map.
    assign cfg_wr    = reg_wr && (reg_addr == event_timer_pkg::CONFIG_OFFSET);
    assign preset_wr = reg_wr && (reg_addr == event_timer_pkg::PRESET_OFFSET);
    assign status_wr = reg_wr && (reg_addr == event_timer_pkg::STATUS_OFFSET);
    assign stop_req  = status_wr && reg_wdata[event_timer_pkg::STAT_RUN_BIT];
    assign clear_req = status_wr && reg_wdata[event_timer_pkg::STAT_EXPIRED_BIT];
    // The immediate start acts on the write itself, not on the stored bit.
    assign now_req   = cfg_wr && reg_wdata[event_timer_pkg::NOW_BIT];

    // External edges are taken from the second synchroniser stage and its delayed copy; own-field edges from the raw input.
    assign ext_rise = s.ext_s2 && !s.ext_prev;
    assign ext_fall = !s.ext_s2 && s.ext_prev;
    assign own_rise = own_field_on && !s.own_prev;
    assign own_fall = !own_field_on && s.own_prev;

    // Any enabled start source; only used while the timer is idle.
    assign start_evt = (s.cfg[event_timer_pkg::EXT_ON_BIT]  && ext_rise)
                    || (s.cfg[event_timer_pkg::EXT_OFF_BIT] && ext_fall)
                    || (s.cfg[event_timer_pkg::OWN_ON_BIT]  && own_rise)
                    || (s.cfg[event_timer_pkg::OWN_OFF_BIT] && own_fall)
                    || (s.cfg[event_timer_pkg::TX_DONE_BIT] && tx_done)
                    || now_req;

    // A preset of zero or one expires on the very first tick after the start.
    assign expiry = s.running && !stop_req && tick && (s.count <= 20'h00001);

    // Next-state logic for the whole block.
    always_comb
    begin
        s_next              = s;
        s_next.expire_pulse = 1'b0;
        s_next.rd_data      = 32'h0000_0000;

        // Field input from a pin: two stages before any logic reads it.
        s_next.ext_s1   = ext_field_pin;
        s_next.ext_s2   = s.ext_s1;
        s_next.ext_prev = s.ext_s2;
        s_next.own_prev = own_field_on;

        // Software writes; bit zero of the configuration is reserved.
        if (cfg_wr)
        begin
            s_next.cfg = reg_wdata[11:0] & event_timer_pkg::CFG_WRITE_MASK;
        end
        if (preset_wr)
        begin
            s_next.preset = reg_wdata[19:0];
        end

        // Stop wins over a start; a running timer ignores further events.
        if (stop_req)
        begin
            s_next.running = 1'b0;
        end
        else if (!s.running)
        begin
            if (start_evt)
            begin
                s_next.running = 1'b1;
                s_next.count   = s.preset;
            end
        end
        else if (expiry)
        begin
            s_next.expire_pulse = 1'b1;
            if (s.cfg[event_timer_pkg::RELOAD_BIT])
            begin
                s_next.count = s.preset;
            end
            else
            begin
                s_next.count   = event_timer_pkg::COUNT_RESET;
                s_next.running = 1'b0;
            end
        end
        else if (tick)
        begin
            s_next.count = s.count - 20'h00001;
        end

        // Sticky expiry flag: a new expiry in the clearing cycle is kept.
        if (clear_req)
        begin
            s_next.expired = 1'b0;
        end
        if (expiry)
        begin
            s_next.expired = 1'b1;
        end

        // Read data appear only in the cycle after the strobe.
        if (reg_rd)
        begin
            case (reg_addr)
                event_timer_pkg::CONFIG_OFFSET:
                begin
                    s_next.rd_data = {20'h00000, s.cfg};
                end
                event_timer_pkg::PRESET_OFFSET:
                begin
                    s_next.rd_data = {12'h000, s.preset};
                end
                event_timer_pkg::COUNT_OFFSET:
                begin
                    s_next.rd_data = {12'h000, s.count};
                end
                event_timer_pkg::STATUS_OFFSET:
                begin
                    s_next.rd_data = {30'h0000_0000, s.expired, s.running};
                end
                default:
                begin
                    s_next.rd_data = 32'h0000_0000;
                end
            endcase
        end
    end

    // State register; every field resets to zero, frozen while the enable is low.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else if (ce)
        begin
            s <= s_next;
        end
    end

    // Outputs straight from the state register.
    assign reg_rdata     = s.rd_data;
    assign timer_running = s.running;
    assign expire_pulse  = s.expire_pulse;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    AST_EXT_ON_START: assert property (
        (ce && !s.running && !stop_req && s.cfg[event_timer_pkg::EXT_ON_BIT] && ext_rise)
        |=> (s.running && s.count == $past(s.preset)))
        else $error("External field on did not start the timer.");

    AST_EXT_OFF_START: assert property (
        (ce && !s.running && !stop_req && s.cfg[event_timer_pkg::EXT_OFF_BIT] && ext_fall)
        |=> (s.running && s.count == $past(s.preset)))
        else $error("External field off did not start the timer.");

    AST_OWN_ON_START: assert property (
        (ce && !s.running && !stop_req && s.cfg[event_timer_pkg::OWN_ON_BIT] && own_rise)
        |=> s.running)
        else $error("Own field on did not start the timer.");

    AST_OWN_OFF_START: assert property (
        (ce && !s.running && !stop_req && s.cfg[event_timer_pkg::OWN_OFF_BIT] && own_fall)
        |=> s.running)
        else $error("Own field off did not start the timer.");

    AST_NOW_START: assert property (
        (ce && !s.running && !stop_req && now_req)
        |=> (s.running && s.count == $past(s.preset)))
        else $error("Immediate start did not start the timer.");

    AST_TX_DONE_START: assert property (
        (ce && !s.running && !stop_req && s.cfg[event_timer_pkg::TX_DONE_BIT] && tx_done)
        |=> s.running)
        else $error("Transmission end did not start the timer.");

    AST_BASE_RATE: assert property (
        (ce && s.running && !stop_req && !s.cfg[event_timer_pkg::MODE_BIT] && base_tick
         && s.count > 20'h00001)
        |=> (s.count + 20'h00001 == $past(s.count)))
        else $error("Timer did not step on an interface tick.");

    AST_PRESCALED_HOLD: assert property (
        (ce && s.running && !stop_req && s.cfg[event_timer_pkg::MODE_BIT] && !scaled_tick)
        |=> (s.running && s.count == $past(s.count)))
        else $error("Timer moved without a prescaled tick.");

    AST_HALT_AT_ZERO: assert property (
        (ce && expiry && !s.cfg[event_timer_pkg::RELOAD_BIT])
        |=> (!s.running && s.count == 20'h00000 && s.expire_pulse && s.expired))
        else $error("Timer did not halt at zero on expiry.");

    AST_RELOAD: assert property (
        (ce && expiry && s.cfg[event_timer_pkg::RELOAD_BIT])
        |=> (s.running && s.count == $past(s.preset) && s.expire_pulse))
        else $error("Timer did not reload on expiry.");

    AST_NO_RESTART: assert property (
        (ce && s.running && !stop_req && !tick && start_evt)
        |=> (s.running && s.count == $past(s.count)))
        else $error("A later start event disturbed the running timer.");

    AST_STOP_WINS: assert property (
        (ce && stop_req)
        |=> !s.running)
        else $error("Stop write did not halt the timer.");

    AST_MODE0_HOLD: assert property (
        (ce && s.running && !stop_req && !s.cfg[event_timer_pkg::MODE_BIT] && !base_tick)
        |=> (s.running && s.count == $past(s.count)))
        else $error("Timer moved without an interface tick.");

    AST_PRESCALED_STEP: assert property (
        (ce && s.running && !stop_req && s.cfg[event_timer_pkg::MODE_BIT] && scaled_tick
         && s.count > 20'h00001)
        |=> (s.count + 20'h00001 == $past(s.count)))
        else $error("Timer did not step on a prescaled tick.");

    AST_CFG_WRITE: assert property (
        (ce && cfg_wr)
        |=> (!s.cfg[0] && (s.cfg | 12'h001) == (12'($past(reg_wdata)) | 12'h001)))
        else $error("Configuration write did not land.");

    AST_EXPIRED_SET: assert property (
        (ce && expiry)
        |=> s.expired)
        else $error("Expiry did not set the sticky flag.");

    AST_EXPIRED_CLEAR: assert property (
        (ce && clear_req && !expiry)
        |=> !s.expired)
        else $error("Clear write did not drop the sticky flag.");

    AST_PULSE_SINGLE: assert property (
        (ce && s.expire_pulse)
        |=> !s.expire_pulse)
        else $error("Expiry pulse lasted more than one cycle.");

    AST_READ_IDLE: assert property (
        (ce && !reg_rd)
        |=> (reg_rdata == 32'h0000_0000))
        else $error("Read data present without a read strobe.");

    // A low enable must leave every state bit untouched, or counts drift during a freeze.
    AST_FREEZE: assert property (
        !ce
        |=> (s == $past(s)))
        else $error("State changed while the enable was low.");

endmodule : event_timer

// >>> tb/event_timer_tb.sv
// Self-checking testbench for the event timer: registers, start sources, rates and reload.
`timescale 1ns/100ps

`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end

module event_timer_tb;

    logic        core_clk;
    logic        rst;
    logic        ce;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        ext_field_pin;
    logic        own_field_on;
    logic        tx_done;
    logic        timer_running;
    logic        expire_pulse;
    int          fails;
    int          n_tests;
    int          cyc;
    int          n;
    int          k;
    real         p;
    logic [31:0] d;
    int          src_bit [5] = '{10, 9, 8, 7, 11};

    event_timer dut
    (
        .core_clk      (core_clk),
        .rst           (rst),
        .ce            (ce),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .ext_field_pin (ext_field_pin),
        .own_field_on  (own_field_on),
        .tx_done       (tx_done),
        .timer_running (timer_running),
        .expire_pulse  (expire_pulse)
    );

    // Free-running 125 MHz clock.
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Cuts a hang short; the ceiling leaves ample room over the slowest rate sweep.
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            fails++;
            wrap_up();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so they are taken right there.
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // Counts settled cycles until the expiry pulse, bounded so a dead timer cannot hang.
    task automatic wait_exp(output int c);
        c = 0;
        do
        begin
            @(posedge core_clk);
            #1 c++;
        end while (expire_pulse !== 1'b1 && c < 20000);
    endtask : wait_exp

    // Makes one start event: ext rise, ext fall, own on, own off, transmit done.
    task automatic fire(input int e);
        @(posedge core_clk);
        case (e)
            0: ext_field_pin <= 1'b1;
            1: ext_field_pin <= 1'b0;
            2: own_field_on  <= 1'b1;
            3: own_field_on  <= 1'b0;
            default: tx_done <= 1'b1;
        endcase
        @(posedge core_clk);
        tx_done <= 1'b0;
    endtask : fire

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // Main sequence of tests.
    initial
    begin
        fails = 0;
        n_tests = 0;
        cyc = 0;
        rst = 1'b1;
        ce = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ext_field_pin = 1'b0;
        own_field_on = 1'b0;
        tx_done = 1'b0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;

        rd(event_timer_pkg::CONFIG_OFFSET, d);
        `CHK("config reset", 32'h00000000, d)
        rd(event_timer_pkg::STATUS_OFFSET, d);
        `CHK("status reset", 32'h00000000, d)
        wr(event_timer_pkg::CONFIG_OFFSET, 32'h00000FBF);
        rd(event_timer_pkg::CONFIG_OFFSET, d);
        `CHK("config rw", 32'h00000FBE, d)
        @(posedge core_clk);
        #1 `CHK("rdata idle", 32'h00000000, reg_rdata)
        wr(event_timer_pkg::CONFIG_OFFSET, 32'h00000000);
        rd(event_timer_pkg::CONFIG_OFFSET, d);
        `CHK("config clear", 32'h00000000, d)
        rd(8'h10, d);
        `CHK("unmapped", 32'h00000000, d)
        $display("test registers done");

        // Mode 0 with the slowest rate code set: the rate field must be ignored.
        wr(event_timer_pkg::PRESET_OFFSET, 32'h00000005);
        wr(event_timer_pkg::CONFIG_OFFSET, 32'h00000078);
        #1 `CHK("immediate run", 1'b1, timer_running)
        wait_exp(n);
        `CHK("mode0 time", 1'b1, n >= 35 && n <= 50)
        `CHK("halt", 1'b0, timer_running)
        rd(event_timer_pkg::COUNT_OFFSET, d);
        `CHK("count zero", 32'h00000000, d)
        rd(event_timer_pkg::STATUS_OFFSET, d);
        `CHK("expired", 32'h00000002, d)
        wr(event_timer_pkg::STATUS_OFFSET, 32'h00000002);
        rd(event_timer_pkg::STATUS_OFFSET, d);
        `CHK("expired clr", 32'h00000000, d)
        $display("test mode0 done");

        // Enable low freezes the count: only three enabled edges separate the two reads.
        wr(event_timer_pkg::PRESET_OFFSET, 32'h00000100);
        wr(event_timer_pkg::CONFIG_OFFSET, 32'h00000040);
        rd(event_timer_pkg::COUNT_OFFSET, d);
        n = d;
        @(posedge core_clk);
        ce <= 1'b0;
        repeat (50) @(posedge core_clk);
        ce <= 1'b1;
        rd(event_timer_pkg::COUNT_OFFSET, d);
        `CHK("ce freeze", 1'b1, (n - d) <= 1)
        wr(event_timer_pkg::STATUS_OFFSET, 32'h00000001);
        $display("test enable done");

        // Reload: the gap between two expiries is three interface ticks.
        wr(event_timer_pkg::PRESET_OFFSET, 32'h00000003);
        wr(event_timer_pkg::CONFIG_OFFSET, 32'h00000042);
        wait_exp(n);
        wait_exp(n);
        `CHK("reload gap", 1'b1, n >= 25 && n <= 31)
        `CHK("reload run", 1'b1, timer_running)
        wr(event_timer_pkg::STATUS_OFFSET, 32'h00000001);
        #1 `CHK("stopped", 1'b0, timer_running)
        $display("test reload done");

        // Prescaled rates; preset 3 keeps neighbouring codes apart despite an early first tick.
        for (k = 0; k < 8; k++)
        begin
            p = 125.0 / 13.56 * (1 << (k + 1));
            wr(event_timer_pkg::CONFIG_OFFSET, 32'h00000000);
            wr(event_timer_pkg::CONFIG_OFFSET, 32'h00000044 | (k << 3));
            wait_exp(n);
            `CHK("rate", 1'b1, n >= 2.0 * p - 2.0 && n <= 3.0 * p + 3.0)
        end
        $display("test rates done");

        // A disabled source must not start the timer.
        wr(event_timer_pkg::CONFIG_OFFSET, 32'h00000780);
        fire(4);
        repeat (10) @(posedge core_clk);
        #1 `CHK("no start", 1'b0, timer_running)

        // Each source starts the timer; a later transmit-done must not restart it.
        for (k = 0; k < 5; k++)
        begin
            wr(event_timer_pkg::CONFIG_OFFSET, 32'h00000800 | (1 << src_bit[k]));
            fire(k);
            #1 n = 0;
            while (timer_running !== 1'b1 && n < 10)
            begin
                @(posedge core_clk);
                #1 n++;
            end
            `CHK("src start", 1'b1, timer_running)
            repeat (12) @(posedge core_clk);
            fire(4);
            wait_exp(n);
            `CHK("no restart", 1'b1, n >= 5 && n <= 16)
        end
        $display("test sources done");
        wrap_up();
    end

endmodule : event_timer_tb
